// ===== rtl/scan_array_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_consts.svh"
module scan_array_end (
    input  wire logic            mclk,
    input  wire logic            rstn,
    scan_link_if.device          link,
    output logic                 scanValid,
    output logic                 intReset,
    output logic                 holdSample
);
    import scan_pkg::*;
    localparam int LEN = `SCAN_CHAIN_LEN;
    logic [LEN-1:0] chain;
    logic [LEN-1:0] next_chain;
    logic         clkQ;
    logic         poweredUp;
    logic         next_poweredUp;
    logic         rise;
    logic         fall;
    logic [7:0]   rstCnt;
    logic [7:0]   next_rstCnt;
    logic         next_intReset;
    logic         next_holdSample;
    logic [7:0]   pos;
    logic         any;

    assign rise = link.scanClock & ~clkQ;
    assign fall = ~link.scanClock & clkQ;

    // chain position of the travelling start bit; the 133rd clock shifts it out, which reinitializes the chain
    always_comb begin
        pos = 8'h00;
        any = 1'b0;
        for (int i = 0; i < LEN; i++) begin
            if (chain[i]) begin
                pos = 8'(i);
                any = 1'b1;
            end
        end
    end

    // start bit captured on a rising clock, then shifted one place per rising edge
    always_comb begin
        next_chain = chain;
        next_poweredUp = poweredUp;
        next_rstCnt = rstCnt;
        next_intReset = intReset;
        next_holdSample = holdSample;
        if (rise) begin
            next_chain = {chain[LEN-2:0], link.scanStart};
            if (chain[LEN-1])
                next_poweredUp = 1'b1;  // 133rd clock empties the chain; first pass only arms
            if (link.scanStart) begin
                next_intReset = 1'b1;   // all sample caps released together
                next_holdSample = 1'b1;
                next_rstCnt = 8'h00;
            end
        end
        if (fall && intReset) begin
            if (rstCnt == 8'(`SCAN_RESET_CLOCKS - 1)) begin
                next_intReset = 1'b0;   // reset ends on falling edge of clock 18
                next_holdSample = 1'b0;
            end else
                next_rstCnt = rstCnt + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chain <= '0;
            clkQ <= 1'b0;
            poweredUp <= 1'b0;
            rstCnt <= 8'h00;
            intReset <= 1'b0;
            holdSample <= 1'b0;
        end else begin
            chain <= next_chain;
            clkQ <= link.scanClock;
            poweredUp <= next_poweredUp;
            rstCnt <= next_rstCnt;
            intReset <= next_intReset;
            holdSample <= next_holdSample;
        end
    end

    // output taps: one value per occupied stage, 132 in all
    assign link.pixelValid = any;
    assign link.pixelIndex = pos;
    assign link.integrating = !intReset;
    assign scanValid = poweredUp;
endmodule
`default_nettype wire

// ===== rtl/scan_consts.svh
`ifndef SCAN_CONSTS_SVH
`define SCAN_CONSTS_SVH
`define SCAN_CHAIN_LEN      132
`define SCAN_CLOCKS         133
`define SCAN_RESET_CLOCKS   18
`define SCAN_LEAD_DUMMIES   2
`define SCAN_REAL_PIXELS    128
`define SCAN_CLK_PERIOD_NS  50
`define SCAN_SETTLE_NS      10000
`define SCAN_SETTLE_CYC     ((`SCAN_SETTLE_NS + `SCAN_CLK_PERIOD_NS - 1) / `SCAN_CLK_PERIOD_NS)
`define SCAN_XFER_NS        8000
`define SCAN_XFER_CYC       ((`SCAN_XFER_NS + `SCAN_CLK_PERIOD_NS - 1) / `SCAN_CLK_PERIOD_NS)
`define SCAN_INT_MIN_NS     125000
`define SCAN_INT_MIN_CYC    ((`SCAN_INT_MIN_NS + `SCAN_CLK_PERIOD_NS - 1) / `SCAN_CLK_PERIOD_NS)
`define SCAN_INT_MAX_NS     2000000
`define SCAN_INT_MAX_CYC    (`SCAN_INT_MAX_NS / `SCAN_CLK_PERIOD_NS)
`define SCAN_HALF_DIV       8
`endif

// ===== rtl/scan_ctrl_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_consts.svh"
module scan_ctrl_end #(
    parameter int HALF_DIV = `SCAN_HALF_DIV,
    parameter int INT_MIN  = `SCAN_INT_MIN_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       scanReq,
    output logic            scanBusy,
    output logic            pixelStrobe,
    output logic [7:0]      pixelNum,
    scan_link_if.ctrl       link
);
    import scan_pkg::*;
    ctlState_t   state;
    ctlState_t   next_state;
    logic [15:0] div;
    logic [15:0] next_div;
    logic [7:0]  pulses;
    logic [7:0]  next_pulses;
    logic [31:0] gap;
    logic [31:0] next_gap;
    logic        sclk;
    logic        next_sclk;
    logic        start;
    logic        next_start;
    logic        next_strobe;
    logic [7:0]  next_num;

    // divider makes the array clock; start rises on a low phase, drops after one rise
    always_comb begin
        next_state = state;
        next_div = div;
        next_pulses = pulses;
        next_gap = gap;
        next_sclk = sclk;
        next_start = start;
        next_strobe = 1'b0;
        next_num = pixelNum;
        case (state)
            CT_IDLE: begin
                if (scanReq) begin
                    next_state = CT_CLOCK;
                    next_start = 1'b1;
                    next_div = 16'h0000;
                    next_pulses = 8'h00;
                end
            end
            CT_CLOCK: begin
                if (div == 16'(HALF_DIV - 1)) begin
                    next_div = 16'h0000;
                    next_sclk = ~sclk;
                    if (!sclk) begin
                        next_pulses = pulses + 8'h01;
                    end else begin
                        next_start = 1'b0;          // low before next rising edge
                        if (link.pixelValid) begin
                            next_strobe = 1'b1;     // sample settled value before the fall
                            next_num = link.pixelIndex;
                        end
                        if (pulses == 8'(`SCAN_CLOCKS)) begin
                            next_state = CT_GAP;    // all 133 clocks given
                            next_gap = 32'h0;
                        end
                    end
                end else
                    next_div = div + 16'h0001;
            end
            CT_GAP: begin
                next_gap = gap + 32'h1;
                if (gap >= 32'(`SCAN_SETTLE_CYC) && gap >= 32'(`SCAN_XFER_CYC) && gap >= 32'(INT_MIN))
                    next_state = CT_IDLE;
            end
            default: next_state = CT_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= CT_IDLE;
            div <= 16'h0000;
            pulses <= 8'h00;
            gap <= 32'h0;
            sclk <= 1'b0;
            start <= 1'b0;
            pixelStrobe <= 1'b0;
            pixelNum <= 8'h00;
        end else begin
            state <= next_state;
            div <= next_div;
            pulses <= next_pulses;
            gap <= next_gap;
            sclk <= next_sclk;
            start <= next_start;
            pixelStrobe <= next_strobe;
            pixelNum <= next_num;
        end
    end

    assign link.scanClock = sclk;
    assign link.scanStart = start;
    assign scanBusy = (state != CT_IDLE);  // first request after reset is the init scan
endmodule
`default_nettype wire

// ===== rtl/scan_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scan_link_if;
    logic      scanStart;   // serial start input of the array
    logic      scanClock;   // array clock, made by the controller
    logic      pixelValid;  // pixel_voltage_output carries a value
    logic [7:0] pixelIndex; // position in the 132-value readout
    logic      integrating; // integrators collecting light
    modport device (input scanStart, input scanClock, output pixelValid, output pixelIndex, output integrating);
    modport ctrl   (output scanStart, output scanClock, input pixelValid, input pixelIndex, input integrating);
endinterface
`default_nettype wire

// ===== rtl/scan_pkg.sv
package scan_pkg;
    typedef logic [7:0] pixIndex_t;
    typedef enum logic [3:0] {
        CT_IDLE  = 4'h1,
        CT_CLOCK = 4'h2,
        CT_GAP   = 4'h4,
        CT_WAIT  = 4'h8
    } ctlState_t;
endpackage

// ===== testbench/linear_photodiode_scan_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_consts.svh"
module linear_photodiode_scan_sequencer_tb_top;
    localparam int HALF = 8;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic       scanReq = 1'b0;
    logic       scanBusy, pixelStrobe, scanValid, intReset, holdSample;
    logic [7:0] pixelNum;
    int         n_fail = 0;
    int         total_checks = 0;
    int         intRun = 0;
    int         lastInt = 0;

    // default integration minimum, so back-to-back scans stay inside the legal window
    scan_link_if link ();
    scan_ctrl_end #(.HALF_DIV(HALF)) u_scan_ctrl_end (.mclk(mclk), .rstn(rstn), .scanReq(scanReq),
        .scanBusy(scanBusy), .pixelStrobe(pixelStrobe), .pixelNum(pixelNum), .link(link));
    scan_array_end u_scan_array_end (.mclk(mclk), .rstn(rstn), .link(link), .scanValid(scanValid),
        .intReset(intReset), .holdSample(holdSample));
    scan_link_sva u_scan_link_sva (.mclk(mclk), .rstn(rstn), .scanStart(link.scanStart),
        .scanClock(link.scanClock), .pixelValid(link.pixelValid), .pixelIndex(link.pixelIndex),
        .integrating(link.integrating));

    always #25 mclk = ~mclk;

    // length of the last integration period in mclk cycles, taken when the next start ends it
    always @(posedge mclk) begin
        if (link.integrating === 1'b1)
            intRun <= intRun + 1;
        else if (intRun != 0) begin
            lastInt <= intRun;
            intRun <= 0;
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task conclude;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one full readout; a request made mid-scan must be ignored
    task scan;
        int idx;
        int i;
        idx = 0;
        scanReq = 1'b1;
        for (i = 0; i < 20 && scanBusy !== 1'b1; i++) @(negedge mclk);
        scanReq = 1'b0;
        check({7'h00, scanBusy}, 8'h01, "request not taken");
        if (scanBusy !== 1'b1)
            return;
        for (i = 0; i < 6000 && scanBusy === 1'b1; i++) begin
            @(negedge mclk);
            scanReq = (i == 700);
            if (pixelStrobe === 1'b1) begin
                check(pixelNum, idx[7:0], "pixel order");
                if (idx != 17) check({7'h00, intReset}, {7'h00, idx < 17}, "integrator reset");
                if (idx != 17) check({7'h00, holdSample}, {7'h00, idx < 17}, "sample hold");
                idx++;
            end
        end
        check({7'h00, scanBusy}, 8'h00, "scan never ended");
        if (scanBusy !== 1'b0)
            return;
        check(idx[7:0], 8'h84, "value count");
        check({7'h00, link.integrating}, 8'h01, "integrating after scan");
        repeat (10) @(negedge mclk);
        check({7'h00, scanBusy}, 8'h00, "refused request started a scan");
    endtask

    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        check({7'h00, scanValid}, 8'h00, "valid before init scan");
        scan();
        $display("init scan done");
        check({7'h00, scanValid}, 8'h01, "valid after init scan");
        scan();
        check({7'h00, lastInt >= (`SCAN_CLOCKS - `SCAN_RESET_CLOCKS) * 2 * HALF + `SCAN_SETTLE_CYC}, 8'h01,
            "integration below clock count plus settling");
        check({7'h00, lastInt >= `SCAN_INT_MIN_CYC}, 8'h01, "integration too short");
        check({7'h00, lastInt <= `SCAN_INT_MAX_CYC}, 8'h01, "integration too long");
        $display("second scan done");
        conclude();
    end
endmodule
`default_nettype wire

// ===== testbench/scan_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module scan_link_sva (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       scanStart,
    input wire logic       scanClock,
    input wire logic       pixelValid,
    input wire logic [7:0] pixelIndex,
    input wire logic       integrating
);
    // every check lives in the mclk domain; the array clock is only sampled
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    property p_first; scanStart && $rose(scanClock) |=> pixelValid && pixelIndex == 8'h00; endproperty
    a_first: assert property (p_first) else $error("no first value after start capture");
    property p_step; pixelValid && !scanStart && $rose(scanClock) && pixelIndex < 8'h83 |=> pixelIndex == $past(pixelIndex) + 8'h01; endproperty
    a_step: assert property (p_step) else $error("index did not advance by one");
    property p_hold; pixelValid && !$rose(scanClock) |=> $stable(pixelIndex); endproperty
    a_hold: assert property (p_hold) else $error("index moved without a clock rise");
    property p_last; pixelValid && pixelIndex == 8'h83 && $rose(scanClock) |=> !pixelValid; endproperty
    a_last: assert property (p_last) else $error("value after the last position");
    property p_range; pixelValid |-> pixelIndex <= 8'h83; endproperty
    a_range: assert property (p_range) else $error("index beyond readout length");
    property p_capture; scanStart && $rose(scanClock) |=> !integrating; endproperty
    a_capture: assert property (p_capture) else $error("start did not stop integration");
    property p_early; pixelValid && pixelIndex < 8'h11 |-> !integrating; endproperty
    a_early: assert property (p_early) else $error("integration before clock 18");
    property p_intEnd; pixelValid && pixelIndex == 8'h11 && $fell(scanClock) |=> integrating; endproperty
    a_intEnd: assert property (p_intEnd) else $error("reset not ended at clock 18 fall");
    property p_single; $rose(scanClock) && pixelValid |-> !scanStart; endproperty
    a_single: assert property (p_single) else $error("start still high at second rise");
endmodule
`default_nettype wire
